// [hw/pfs_pkg.sv]
// Purpose: Shared constants and types for the program flash sequencer pair.
// Assumes: 100 MHz core clock; one link between core-side controller and sequencer.
// Notes:   Control byte layout, key values, timing and host register offsets live here.
package pfs_pkg;

   // Table pointer and flash geometry.
   localparam int PTR_W        = 22;
   localparam int PTR_STEP_W   = 21;
   localparam int ROW_LSB      = 6;
   localparam int ROW_W        = PTR_W - ROW_LSB;
   localparam int WORD_ADDR_W  = PTR_W - 1;
   localparam int DATA_W       = 16;
   localparam int BYTE_W       = 8;
   localparam int ROW_WORDS    = 32;
   localparam int ROW_BYTES    = 64;

   // Control byte bit positions.
   localparam int CTL_PROG_BIT  = 7;
   localparam int CTL_CFG_BIT   = 6;
   localparam int CTL_ERASE_BIT = 4;
   localparam int CTL_ABORT_BIT = 3;
   localparam int CTL_ALLOW_BIT = 2;
   localparam int CTL_START_BIT = 1;

   // Unlock key values.
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // Erase timing: figure in microseconds, clock in MHz.
   localparam int ERASE_TIME_US  = 2000;
   localparam int CLK_FREQ_MHZ   = 100;
   localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_FREQ_MHZ;

   // Host register byte offsets.
   localparam logic [4:0] REG_PTR    = 5'h00;
   localparam logic [4:0] REG_CTRL   = 5'h04;
   localparam logic [4:0] REG_KEY    = 5'h08;
   localparam logic [4:0] REG_TREAD  = 5'h0c;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam int         ST_BUSY_BIT = 0;
   localparam int         ST_DONE_BIT = 1;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operations passed over the link.
   typedef enum logic [2:0] {
      PFS_OP_PTR,
      PFS_OP_CTRL,
      PFS_OP_KEY,
      PFS_OP_TREAD,
      PFS_OP_CLR_DONE
   } pfs_op_type;

   // Pointer update modes for a table read.
   localparam logic [1:0] TRD_KEEP    = 2'h0;
   localparam logic [1:0] TRD_POSTINC = 2'h1;
   localparam logic [1:0] TRD_POSTDEC = 2'h2;
   localparam logic [1:0] TRD_PREINC  = 2'h3;

endpackage

// [hw/pfs_link_if.sv]
// Purpose: Link between the core-side controller and the flash sequencer.
// Assumes: Both ends on clk_i; an operation is taken when op_valid is high and stall is low.
// Notes:   The sequencer end reflects its pointer, control byte and latch continuously.
`timescale 1ns/100ps
interface pfs_link_if;
   import pfs_pkg::*;

   // Operation from the core side.
   logic                op_valid;
   pfs_op_type          op_code;
   logic [PTR_W-1:0]    op_data;
   // State shown by the sequencer.
   logic                stall;
   logic [PTR_W-1:0]    ptr;
   logic [BYTE_W-1:0]   ctrl;
   logic [BYTE_W-1:0]   latch;
   logic                done_flag;

   modport core (output op_valid, op_code, op_data,
                 input  stall, ptr, ctrl, latch, done_flag);
   modport seq  (input  op_valid, op_code, op_data,
                 output stall, ptr, ctrl, latch, done_flag);
endinterface

// [hw/pfs_sequencer.sv]
// Purpose: Flash sequencer: byte table reads and self-timed, key-guarded row erase.
// Assumes: Flash array answers a word read combinationally while flash_rd_en_o is high.
// Notes:   The core is halted through the link stall while a fetch or erase runs.
`timescale 1ns/100ps
module pfs_sequencer
   import pfs_pkg::*;
#(
   parameter int ERASE_COUNT = ERASE_CYCLES
) (
   input  wire logic                   clk_i,
   input  wire logic                   reset_n_i,
   pfs_link_if.seq                     link,
   output logic                        flash_rd_en_o,
   output logic [WORD_ADDR_W-1:0]      flash_word_addr_o,
   input  wire logic [DATA_W-1:0]      flash_rd_data_i,
   output logic                        flash_erase_o,
   output logic [ROW_W-1:0]            flash_erase_row_o,
   input  wire logic                   flash_interrupted_i
);

   typedef enum {SEQ_IDLE, SEQ_FETCH, SEQ_ERASE} pfs_seq_type;
   typedef enum {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} pfs_key_type;

   localparam int CNT_W = $clog2(ERASE_COUNT + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ERASE_COUNT - 1);

   pfs_seq_type         state;
   pfs_key_type         key_state;
   logic [PTR_W-1:0]    table_byte_pointer;
   logic [BYTE_W-1:0]   table_byte_latch;
   logic [PTR_W-1:0]    fetch_addr;
   logic [1:0]          fetch_mode;
   logic [CNT_W-1:0]    erase_cnt;
   logic                program_space_select;
   logic                config_space_select;
   logic                row_erase_select;
   logic                write_allow;
   logic                write_start;
   logic                write_abort_flag;
   logic                write_done_irq_flag;
   logic                sync1;
   logic                sync2;
   logic                sync3;
   logic                interrupt_seen;
   logic                take;
   logic                ctrl_wr;
   logic                start_req;
   logic                start_ok;
   logic                erase_end;
   logic                abort_set;

   // Moves the low 21 pointer bits by one step up or down; the top bit stays.
   function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic up);
      logic [PTR_STEP_W-1:0] low;
      low = up ? p[PTR_STEP_W-1:0] + 1'b1 : p[PTR_STEP_W-1:0] - 1'b1;
      return {p[PTR_W-1], low};
   endfunction

   // Operation acceptance and decoding of a start attempt.
   assign take      = link.op_valid && (state == SEQ_IDLE);
   assign ctrl_wr   = take && (link.op_code == PFS_OP_CTRL);
   assign start_req = ctrl_wr && link.op_data[CTL_START_BIT];
   assign start_ok  = start_req && (key_state == KEY_ARMED)
                      && link.op_data[CTL_ALLOW_BIT] && link.op_data[CTL_PROG_BIT]
                      && !link.op_data[CTL_CFG_BIT] && link.op_data[CTL_ERASE_BIT];
   assign erase_end = (state == SEQ_ERASE) && (erase_cnt == CNT_LAST);
   assign abort_set = (start_req && !start_ok) || (sync3 && sync2 && !interrupt_seen);

   // Outputs shown on the link; the core halts while stall is high.
   assign link.stall     = (state != SEQ_IDLE);
   assign link.ptr       = table_byte_pointer;
   assign link.latch     = table_byte_latch;
   assign link.done_flag = write_done_irq_flag;
   assign link.ctrl      = {program_space_select, config_space_select, 1'b0, row_erase_select,
                            write_abort_flag, write_allow, write_start, 1'b0};

   // Flash array drive: one word read in the fetch cycle, row erase held through the timer.
   assign flash_rd_en_o     = (state == SEQ_FETCH);
   assign flash_word_addr_o = fetch_addr[PTR_W-1:1];
   assign flash_erase_o     = (state == SEQ_ERASE);
   assign flash_erase_row_o = table_byte_pointer[PTR_W-1:ROW_LSB];

   // Main sequence: idle, one-cycle fetch, or the timed row erase.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= SEQ_IDLE;
      end else begin
         case (state)
            SEQ_IDLE: begin
               if (take && link.op_code == PFS_OP_TREAD) begin
                  state <= SEQ_FETCH;
               end else if (start_ok) begin
                  state <= SEQ_ERASE;
               end
            end
            SEQ_FETCH: begin
               state <= SEQ_IDLE;
            end
            SEQ_ERASE: begin
               if (erase_end) begin
                  state <= SEQ_IDLE;
               end
            end
            default: begin
               state <= SEQ_IDLE;
            end
         endcase
      end
   end

   // Internal programming timer for the erase stall.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         erase_cnt <= '0;
      end else if (state == SEQ_ERASE && !erase_end) begin
         erase_cnt <= erase_cnt + 1'b1;
      end else begin
         erase_cnt <= '0;
      end
   end

   // Unlock key tracking; any other operation breaks the sequence.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         key_state <= KEY_IDLE;
      end else if (take) begin
         if (link.op_code != PFS_OP_KEY) begin
            key_state <= KEY_IDLE;
         end else if (link.op_data[BYTE_W-1:0] == KEY_FIRST) begin
            key_state <= KEY_GOT_FIRST;
         end else if (key_state == KEY_GOT_FIRST &&
                      link.op_data[BYTE_W-1:0] == KEY_SECOND) begin
            key_state <= KEY_ARMED;
         end else begin
            key_state <= KEY_IDLE;
         end
      end
   end

   // Table pointer: loads, pre-increment at start and post adjust after the fetch.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         table_byte_pointer <= '0;
         fetch_addr         <= '0;
         fetch_mode         <= TRD_KEEP;
      end else if (take && link.op_code == PFS_OP_PTR) begin
         table_byte_pointer <= link.op_data;
      end else if (take && link.op_code == PFS_OP_TREAD) begin
         fetch_mode <= link.op_data[1:0];
         if (link.op_data[1:0] == TRD_PREINC) begin
            fetch_addr         <= ptr_step(table_byte_pointer, 1'b1);
            table_byte_pointer <= ptr_step(table_byte_pointer, 1'b1);
         end else begin
            fetch_addr <= table_byte_pointer;
         end
      end else if (state == SEQ_FETCH) begin
         if (fetch_mode == TRD_POSTINC) begin
            table_byte_pointer <= ptr_step(table_byte_pointer, 1'b1);
         end else if (fetch_mode == TRD_POSTDEC) begin
            table_byte_pointer <= ptr_step(table_byte_pointer, 1'b0);
         end
      end
   end

   // Table latch takes one byte of the fetched word.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         table_byte_latch <= '0;
      end else if (state == SEQ_FETCH) begin
         table_byte_latch <= fetch_addr[0] ? flash_rd_data_i[DATA_W-1:BYTE_W]
                                           : flash_rd_data_i[BYTE_W-1:0];
      end
   end

   // Control bits; start is cleared by the timer, not by software; erase select by the timer or a control write.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         program_space_select <= 1'b0;
         config_space_select  <= 1'b0;
         row_erase_select     <= 1'b0;
         write_allow          <= 1'b0;
         write_start          <= 1'b0;
      end else if (erase_end) begin
         write_start      <= 1'b0;
         row_erase_select <= 1'b0;
      end else if (ctrl_wr) begin
         program_space_select <= link.op_data[CTL_PROG_BIT];
         config_space_select  <= link.op_data[CTL_CFG_BIT];
         row_erase_select     <= link.op_data[CTL_ERASE_BIT];
         write_allow          <= link.op_data[CTL_ALLOW_BIT];
         write_start          <= start_ok;
      end
   end

   // Abort flag: set by a refused start or the array's first interrupted-operation indication, cleared on completion.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         write_abort_flag <= 1'b0;
      end else if (abort_set) begin
         write_abort_flag <= 1'b1;
      end else if (erase_end) begin
         write_abort_flag <= 1'b0;
      end else if (ctrl_wr) begin
         write_abort_flag <= link.op_data[CTL_ABORT_BIT];
      end
   end

   // Done flag: set on completion; a clear in the same cycle loses.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         write_done_irq_flag <= 1'b0;
      end else if (erase_end) begin
         write_done_irq_flag <= 1'b1;
      end else if (take && link.op_code == PFS_OP_CLR_DONE) begin
         write_done_irq_flag <= 1'b0;
      end
   end

   // Three-stage capture of the array's interrupted-operation indication after reset.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1          <= 1'b0;
         sync2          <= 1'b0;
         sync3          <= 1'b0;
         interrupt_seen <= 1'b0;
      end else begin
         sync1 <= flash_interrupted_i;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 && sync3) begin
            interrupt_seen <= 1'b1;
         end
      end
   end

endmodule

// [hw/pfs_core_ctrl.sv]
// Purpose: Core-side controller: AXI4-Lite registers turned into link operations.
// Assumes: One write and one read at most in flight; link stall halts issue.
// Notes:   A mapped write answers once its operation has been taken by the sequencer; others answer at once.
`timescale 1ns/100ps
module pfs_core_ctrl
   import pfs_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          reset_n_i,
   pfs_link_if.core           link,
   input  wire logic [4:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [4:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready
);

   logic                aw_held;
   logic                w_held;
   logic [4:0]          aw_addr;
   logic [31:0]         w_data;
   logic                op_pend;
   logic                issue;
   logic                mapped;
   logic [31:0]         rd_value;
   logic                rd_ok;

   // Address and data are taken independently, then decoded together.
   assign s_axi_awready = !aw_held && !op_pend && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !op_pend && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign issue         = op_pend && !link.stall;
   assign link.op_valid = op_pend;

   // A complete write becomes an operation unless its offset is unknown or it clears nothing.
   assign mapped = (aw_addr == REG_PTR) || (aw_addr == REG_CTRL) || (aw_addr == REG_KEY)
                   || (aw_addr == REG_TREAD) || (aw_addr == REG_STATUS && w_data[ST_DONE_BIT]);

   // Address and data holding.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
      end else if (aw_held && w_held) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
         end
      end
   end

   // Decode a complete write into one link operation; unmapped writes answer at once.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         op_pend      <= 1'b0;
         link.op_code <= PFS_OP_PTR;
         link.op_data <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (aw_held && w_held) begin
         case (aw_addr)
            REG_PTR:    link.op_code <= PFS_OP_PTR;
            REG_CTRL:   link.op_code <= PFS_OP_CTRL;
            REG_KEY:    link.op_code <= PFS_OP_KEY;
            REG_TREAD:  link.op_code <= PFS_OP_TREAD;
            REG_STATUS: link.op_code <= PFS_OP_CLR_DONE;
            default:    link.op_code <= PFS_OP_PTR;
         endcase
         link.op_data <= w_data[PTR_W-1:0];
         op_pend      <= mapped;
         s_axi_bvalid <= !mapped;
         s_axi_bresp  <= (mapped || aw_addr == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (issue) begin
         op_pend      <= 1'b0;
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode of the sequencer's reflected state.
   always_comb begin
      rd_value = '0;
      rd_ok    = 1'b1;
      case (s_axi_araddr)
         REG_PTR:    rd_value = 32'(link.ptr);
         REG_CTRL:   rd_value = 32'(link.ctrl);
         REG_KEY:    rd_value = '0;
         REG_TREAD:  rd_value = 32'(link.latch);
         REG_STATUS: rd_value = 32'({link.done_flag, (link.stall || op_pend)});
         default:    rd_ok    = 1'b0;
      endcase
   end

   // Read answer one cycle after the address is taken.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_value;
         s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// [tb/pfs_link_monitor.sv]
// Purpose: Concurrent checks on the link between the core-side controller and the sequencer.
// Assumes: One clock; ERASE_COUNT matches the sequencer instance.
// Notes:   Flash pins are judged by the bench; this module sees the link only.
`timescale 1ns/100ps
module pfs_link_monitor
   import pfs_pkg::*;
#(
   parameter int ERASE_COUNT = ERASE_CYCLES
) (
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              op_valid,
   input  wire pfs_op_type        op_code,
   input  wire logic [PTR_W-1:0]  op_data,
   input  wire logic              stall,
   input  wire logic [PTR_W-1:0]  ptr,
   input  wire logic [BYTE_W-1:0] ctrl,
   input  wire logic [BYTE_W-1:0] latch,
   input  wire logic              done_flag
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic       taken;
   logic       ok_bits;
   logic [1:0] unlock;
   int         run;
   // An operation moves when offered while the sequencer is free.
   assign taken   = op_valid && !stall;
   assign ok_bits = op_data[CTL_PROG_BIT] && !op_data[CTL_CFG_BIT]
                    && op_data[CTL_ERASE_BIT] && op_data[CTL_ALLOW_BIT];
   // Tracks progress through the key pair; any other operation breaks it.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         unlock <= 2'h0;
      else if (taken)
         unlock <= (op_code != PFS_OP_KEY) ? 2'h0 : (op_data[7:0] == KEY_FIRST) ? 2'h1 :
                   (op_data[7:0] == KEY_SECOND && unlock == 2'h1) ? 2'h2 : 2'h0;
   end
   // Counts the cycles of the current stall so its length can be judged as it ends.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         run <= 0;
      else
         run <= stall ? run + 1 : 0;
   end
   sequence s_tread;
      taken && op_code == PFS_OP_TREAD;
   endsequence
   sequence s_start;
      taken && op_code == PFS_OP_CTRL && op_data[CTL_START_BIT];
   endsequence
   sequence s_fetch;
      stall ##1 !stall;
   endsequence
   a_fetch_one_cycle: assert property (s_tread |=> s_fetch)
      else $error("table read did not stall for exactly one cycle");
   a_post_inc_ptr: assert property (s_tread ##0 op_data[1:0] == TRD_POSTINC |=> ##1
      ptr == ((($past(ptr, 2) + 22'h1) & 22'h1fffff) | ($past(ptr, 2) & 22'h200000)))
      else $error("pointer not advanced by one after read");
   a_stall_len: assert property ($fell(stall) |-> run == 1 || run == ERASE_COUNT)
      else $error("stall length wrong");
   a_erase_end_flags: assert property ($fell(stall) && run == ERASE_COUNT |-> done_flag
      && !ctrl[CTL_START_BIT] && !ctrl[CTL_ERASE_BIT] && !ctrl[CTL_ABORT_BIT])
      else $error("erase end flags wrong");
   a_erase_go: assert property (s_start ##0 (unlock == 2'h2 && ok_bits) |=> stall
      && ctrl[CTL_START_BIT]) else $error("armed start did not begin erase");
   a_start_refused: assert property (s_start ##0 !(unlock == 2'h2 && ok_bits) |=> !stall
      && ctrl[CTL_ABORT_BIT]) else $error("improper start not refused");
   a_op_held: assert property (op_valid && stall |=> op_valid && $stable(op_code)
      && $stable(op_data)) else $error("operation changed while stalled");
   a_latch_on_fetch: assert property ($changed(latch) |-> $past(stall))
      else $error("latch changed outside a fetch");
   a_done_holds: assert property (done_flag && !(taken && op_code == PFS_OP_CLR_DONE)
      |=> done_flag) else $error("done flag lost without clear");
endmodule

// [tb/testbench.sv]
// Purpose: Drives both ends of the flash sequencer pair over AXI4-Lite and checks results.
// Assumes: Flash word data is a function of its address; erase shortened to EC cycles.
// Notes:   Unmapped reads return only a response code, so their data is not compared.
`timescale 1ns/100ps
module testbench;
   import pfs_pkg::*;
   localparam int EC = 20;
   localparam logic [1:0] MODES [5] = '{TRD_KEEP, TRD_POSTINC, TRD_POSTINC, TRD_POSTDEC,
                                        TRD_PREINC};
   localparam logic [23:0] BAD [4] = '{24'haa5596, 24'h55aad6, 24'h55aa86, 24'h55aa92};
   logic        clk_i = 1'b0, reset_n_i = 1'b0, flash_interrupted_i = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        flash_rd_en_o, flash_erase_o;
   logic [20:0] flash_word_addr_o;
   logic [15:0] flash_rd_data_i;
   logic [15:0] flash_erase_row_o;
   int          fails = 0, compares = 0, cyc = 0;
   pfs_link_if link();
   pfs_core_ctrl u_pfs_core_ctrl (.clk_i, .reset_n_i, .link, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pfs_sequencer #(.ERASE_COUNT(EC)) u_pfs_sequencer (.clk_i, .reset_n_i, .link,
      .flash_rd_en_o, .flash_word_addr_o, .flash_rd_data_i, .flash_erase_o,
      .flash_erase_row_o, .flash_interrupted_i);
   pfs_link_monitor #(.ERASE_COUNT(EC)) u_pfs_link_monitor (.clk_i, .reset_n_i,
      .op_valid(link.op_valid), .op_code(link.op_code), .op_data(link.op_data),
      .stall(link.stall), .ptr(link.ptr), .ctrl(link.ctrl), .latch(link.latch),
      .done_flag(link.done_flag));
   // Array model: word carries its address; off-read the lines show the inverse.
   assign flash_rd_data_i = flash_rd_en_o ? {flash_word_addr_o[7:0] ^ 8'h3c,
      flash_word_addr_o[7:0]} : ~{flash_word_addr_o[7:0] ^ 8'h3c, flash_word_addr_o[7:0]};
   // Free-running core clock.
   always #5 clk_i = ~clk_i;
   // Byte the array model gives for a byte pointer.
   function automatic logic [7:0] fbyte(input logic [21:0] p);
      return p[0] ? (p[8:1] ^ 8'h3c) : p[8:1];
   endfunction
   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, er);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] ex, input logic [1:0] er = 2'h0);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rresp", s_axi_rresp, er);
      if (er == RESP_OKAY) chk("rdata", s_axi_rdata, ex);
   endtask
   // Cuts a hang short.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         summarize();
      end
   end
   // Main sequence.
   initial begin
      logic [21:0] p;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      p = 22'h3ffffe;
      wr(REG_PTR, 32'(p));
      foreach (MODES[i]) begin
         if (MODES[i] == TRD_PREINC) p[20:0] = p[20:0] + 21'h1;
         wr(REG_TREAD, 32'(MODES[i]));
         rd(REG_TREAD, 32'(fbyte(p)));
         if (MODES[i] == TRD_POSTINC) p[20:0] = p[20:0] + 21'h1;
         if (MODES[i] == TRD_POSTDEC) p[20:0] = p[20:0] - 21'h1;
         rd(REG_PTR, 32'(p));
      end
      $display("test table_read done");
      wr(REG_PTR, 32'h2abc7f);
      wr(REG_CTRL, 32'h94);
      wr(REG_KEY, 32'(KEY_FIRST));
      wr(REG_KEY, 32'(KEY_SECOND));
      wr(REG_CTRL, 32'h96);
      rd(REG_STATUS, 32'h1);
      chk("erase_on", 32'(flash_erase_o), 32'h1);
      chk("erase_row", 32'(flash_erase_row_o), 32'haaf1);
      wait (link.stall === 1'b0);
      rd(REG_CTRL, 32'h84);
      rd(REG_STATUS, 32'h2);
      wr(REG_STATUS, 32'h2);
      rd(REG_STATUS, 32'h0);
      $display("test row_erase done");
      foreach (BAD[i]) begin
         wr(REG_CTRL, 32'h0);
         wr(REG_KEY, 32'(BAD[i][23:16]));
         wr(REG_KEY, 32'(BAD[i][15:8]));
         wr(REG_CTRL, 32'(BAD[i][7:0]));
         rd(REG_CTRL, 32'((BAD[i][7:0] & 8'hfd) | 8'h08));
         chk("erase_on", 32'(flash_erase_o), 32'h0);
      end
      $display("test bad_start done");
      rd(REG_KEY, 32'h0);
      wr(5'h14, 32'h1, RESP_SLVERR);
      rd(5'h14, 32'h0, RESP_SLVERR);
      wr(REG_CTRL, 32'h0);
      flash_interrupted_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      flash_interrupted_i <= 1'b0;
      rd(REG_CTRL, 32'h08);
      $display("test map_and_abort done");
      summarize();
   end
endmodule
